// ---- itm_pkg.sv ----
package itm_pkg;

    // Pin and signal counts of the monitored I/O.
    localparam int ITM_NIN = 9;
    localparam int ITM_NOUT = 13;

    // Register byte offsets on the APB.
    localparam logic [7:0] ITM_A_CTRL = 8'h00;
    localparam logic [7:0] ITM_A_RX = 8'h04;
    localparam logic [7:0] ITM_A_POL = 8'h08;
    localparam logic [7:0] ITM_A_ASN = 8'h0C;
    localparam logic [7:0] ITM_A_FOUT = 8'h10;
    localparam logic [7:0] ITM_A_STAT = 8'h14;
    localparam logic [7:0] ITM_A_IN = 8'h18;
    localparam logic [7:0] ITM_A_OUT = 8'h1C;
    localparam logic [7:0] ITM_A_QRY = 8'h20;

    // Control register field positions.
    localparam int ITM_C_ENTER = 0;
    localparam int ITM_C_DISP = 1;
    localparam int ITM_C_REP = 2;
    localparam int ITM_C_QRY = 3;
    localparam int ITM_C_DAISY = 4;
    localparam int ITM_C_IDX = 8;

    // Reset values of the software registers.
    localparam logic [8:0] ITM_POL_RST = 9'h000;
    localparam logic [12:0] ITM_ASN_RST = 13'h1FFF;
    localparam logic [12:0] ITM_FOUT_RST = 13'h0000;

    // Characters that the block recognises or sends.
    localparam logic [7:0] ITM_CH_ESC = 8'h1B;
    localparam logic [7:0] ITM_CH_SPC = 8'h20;
    localparam logic [7:0] ITM_CH_LF = 8'h0A;
    localparam logic [7:0] ITM_CH_CR = 8'h0D;
    localparam logic [7:0] ITM_CH_ZERO = 8'h30;

    // Report pages: I/O, parameters, position, alarms.
    localparam logic [1:0] ITM_LAST_PAGE = 2'h3;

    // Query index range: inputs first, then outputs.
    localparam logic [4:0] ITM_IDX_NSIG = 5'h16;

    // Display refresh period and its cycle count at 125 MHz.
    // The count is a parameter of the monitor, so a bench may shorten it without touching this package.
    localparam int ITM_DISP_PERIOD_MS = 150;
    localparam int ITM_CLK_KHZ = 125000;
    localparam int ITM_DISP_CYC = ITM_DISP_PERIOD_MS * ITM_CLK_KHZ;

    // Transmit sequencer: value byte, then line end.
    typedef enum logic [1:0] {
        TX_IDLE = 2'b00,
        TX_VAL = 2'b01,
        TX_END = 2'b11
    } itm_tx_e;

    // Whole state of the block.
    typedef struct packed {
        logic test;
        logic disp;
        logic rep;
        logic [1:0] page;
        logic refused;
        logic daisy;
        logic [4:0] idx;
        logic [8:0] pol;
        logic [12:0] asn;
        logic [12:0] fout;
        logic [12:0] tout;
        logic [12:0] save;
        logic qry;
        logic [12:0] out;
        logic [8:0] iact;
        logic [8:0] in_s1;
        logic [8:0] in_s2;
        logic [8:0] in_s3;
        logic [8:0] in_q;
        logic [24:0] tmr;
        itm_tx_e tx;
        logic txv;
        logic [7:0] txd;
        logic stop;
        logic seq_ok;
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
    } itm_state_s;

endpackage : itm_pkg

// ---- itm_monitor.sv ----
`timescale 1ns/100ps

module itm_monitor
    import itm_pkg::*;
#(
    parameter int DISP_CYC = ITM_DISP_CYC
) (
    // Clock and reset.
    input wire logic pclk,
    input wire logic presetn,
    // APB register port.
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic pready,
    output logic [31:0] prdata,
    output logic pslverr,
    // Input pins and their function-side view.
    input wire logic [8:0] in_pin,
    output logic [8:0] in_act,
    // Output pins.
    output logic [12:0] out_pin,
    // Controller status and sequence control.
    input wire logic seq_running,
    input wire logic motion_active,
    input wire logic alarm_active,
    input wire logic seq_start_req,
    output logic seq_start_ok,
    output logic stop_motion,
    // Terminal transmit byte stream.
    output logic tx_valid,
    output logic [7:0] tx_data,
    input wire logic tx_ready
);

    // Current and next state.
    itm_state_s s;
    itm_state_s n;
    // Polarity-adjusted inputs.
    logic [8:0] lin;
    // Value selected by the current query index.
    logic qv;
    // Decoded APB access phases: any access cycle, and the completing write.
    logic acc;
    logic wr;
    // A write to the receive register stands for one character from the terminal.
    logic rxv;
    // The character itself and the output bit that it toggles.
    logic [7:0] ch;
    logic [4:0] key;
    // High when the character names one of the thirteen outputs.
    logic mapped;

    // Maps a toggle character to its output index, 31 for none.
    // Characters outside the table map past the last output and so toggle nothing.
    function automatic logic [4:0] key_index(input logic [7:0] c);
        case (c)
            8'h31: key_index = 5'h00;
            8'h32: key_index = 5'h01;
            8'h33: key_index = 5'h02;
            8'h34: key_index = 5'h03;
            8'h4D: key_index = 5'h04;
            8'h52: key_index = 5'h05;
            8'h45: key_index = 5'h06;
            8'h48: key_index = 5'h07;
            8'h41: key_index = 5'h08;
            8'h50: key_index = 5'h09;
            8'h42: key_index = 5'h0A;
            8'h44: key_index = 5'h0B;
            8'h4C: key_index = 5'h0C;
            default: key_index = 5'h1F;
        endcase
    endfunction : key_index

    // Logical state is the settled pin level seen through polarity.
    assign lin = s.in_q ^ s.pol;
    assign acc = psel & penable;
    assign wr = acc & s.pready & pwrite & ~s.pslverr;
    assign rxv = wr && (paddr == ITM_A_RX);
    assign ch = pwdata[7:0];
    assign key = key_index(ch);
    assign mapped = (key < 5'(ITM_NOUT));

    // Query value: inputs come first, then the outputs as driven.
    // Indices past the last output read as 0 rather than wrapping onto an input.
    always_comb begin
        if (s.idx < 5'(ITM_NIN)) begin
            qv = lin[s.idx[3:0]];
        end else if (s.idx < ITM_IDX_NSIG) begin
            qv = s.out[4'(s.idx - 5'(ITM_NIN))];
        end else begin
            qv = 1'b0;
        end
    end

    // Next-state logic of the whole block.
    always_comb begin
        n = s;
        n.stop = 1'b0;
        // Three-stage synchroniser; the value moves once stages two and three agree.
        // Stage one alone may be metastable, so only stages two and three are compared.
        n.in_s1 = in_pin;
        n.in_s2 = s.in_s1;
        n.in_s3 = s.in_s2;
        if (s.in_s2 == s.in_s3) begin
            n.in_q = s.in_s3;
        end
        // Functions see no inputs while the test runs.
        n.iact = s.test ? '0 : lin;
        n.seq_ok = seq_start_req & ~s.test;
        // Test levels replace the function levels on the pins.
        n.out = s.test ? s.tout : (s.fout & s.asn);
        // One wait state, then the answer with pready.
        // Reads are decoded in the first access cycle, so data and error stand with pready.
        n.pready = acc & ~s.pready;
        if (acc && !s.pready) begin
            n.pslverr = 1'b0;
            n.prdata = '0;
            unique case (paddr)
                ITM_A_CTRL: n.prdata = {19'h0, s.idx, 3'h0, s.daisy, 4'h0};
                ITM_A_RX: n.prdata = '0;
                ITM_A_POL: n.prdata = {23'h0, s.pol};
                ITM_A_ASN: n.prdata = {19'h0, s.asn};
                ITM_A_FOUT: n.prdata = {19'h0, s.fout};
                ITM_A_STAT: n.prdata = {26'h0, s.page, s.refused, s.rep, s.disp, s.test};
                ITM_A_IN: n.prdata = {23'h0, lin};
                ITM_A_OUT: n.prdata = {19'h0, s.out};
                ITM_A_QRY: n.prdata = {31'h0, s.qry};
                default: n.pslverr = 1'b1;
            endcase
        end
        // Register writes take effect on the edge that completes the transfer.
        if (wr) begin
            unique case (paddr)
                ITM_A_CTRL: begin
                    n.idx = pwdata[ITM_C_IDX +: 5];
                    n.daisy = pwdata[ITM_C_DAISY];
                    if (pwdata[ITM_C_QRY]) begin
                        n.qry = qv;
                    end
                    // Entry is refused while the controller is busy or in alarm.
                    if (pwdata[ITM_C_ENTER] && !s.test) begin
                        if (seq_running || motion_active || alarm_active) begin
                            n.refused = 1'b1;
                        end else begin
                            n.refused = 1'b0;
                            n.test = 1'b1;
                            n.tout = s.out;
                            n.save = s.out;
                        end
                    end
                    // A new display simply replaces the old one: one query at a time.
                    if (pwdata[ITM_C_DISP] && !s.test) begin
                        n.disp = 1'b1;
                        n.tmr = '0;
                    end
                    if (pwdata[ITM_C_REP] && !s.test) begin
                        n.rep = 1'b1;
                        n.page = '0;
                    end
                end
                ITM_A_POL: n.pol = pwdata[8:0];
                ITM_A_ASN: n.asn = pwdata[12:0];
                ITM_A_FOUT: n.fout = pwdata[12:0];
                default: n.refused = s.refused;
            endcase
        end
        // Received characters; test mode has first claim on them.
        // Outside the test and the report, only escape means anything here.
        if (rxv) begin
            if (s.test) begin
                if (ch == ITM_CH_ESC) begin
                    n.test = 1'b0;
                    n.fout = s.save;
                end else if (ch == ITM_CH_SPC) begin
                    n.tout = '0;
                end else if (mapped && s.asn[key[3:0]]) begin
                    n.tout[key[3:0]] = ~s.tout[key[3:0]];
                end
                // Any other character leaves the test state untouched.
            end else if (s.rep) begin
                if (ch == ITM_CH_SPC && s.page != ITM_LAST_PAGE) begin
                    n.page = s.page + 2'h1;
                end else begin
                    n.rep = 1'b0;
                end
            end else if (ch == ITM_CH_ESC) begin
                // Escape is spent on the display before it reaches the motion.
                if (s.disp) begin
                    n.disp = 1'b0;
                end else begin
                    n.stop = motion_active;
                end
            end
        end
        // Refresh timer of the continuous display.
        // A stopped display holds its count; a start from stopped clears it, so the first value waits a full period.
        if (s.disp && n.disp) begin
            if (s.tmr == 25'(DISP_CYC - 1)) begin
                n.tmr = '0;
            end else begin
                n.tmr = s.tmr + 25'h1;
            end
        end
        // Transmit sequencer; a busy sender skips a refresh rather than queue it.
        // Only one byte pair is in flight, so a report page and a refresh never interleave.
        unique case (s.tx)
            TX_IDLE: begin
                if (s.disp && s.tmr == 25'(DISP_CYC - 1)) begin
                    n.txv = 1'b1;
                    n.txd = ITM_CH_ZERO + {7'h0, qv};
                    n.tx = TX_VAL;
                end else if (wr && paddr == ITM_A_CTRL && pwdata[ITM_C_REP] && !s.test) begin
                    n.txv = 1'b1;
                    n.txd = ITM_CH_ZERO;
                    n.tx = TX_VAL;
                end else if (rxv && s.rep && ch == ITM_CH_SPC && s.page != ITM_LAST_PAGE) begin
                    n.txv = 1'b1;
                    n.txd = ITM_CH_ZERO + {6'h0, s.page + 2'h1};
                    n.tx = TX_VAL;
                end
            end
            TX_VAL: begin
                if (tx_ready) begin
                    n.txd = s.daisy ? ITM_CH_LF : ITM_CH_CR;
                    n.tx = TX_END;
                end
            end
            TX_END: begin
                if (tx_ready) begin
                    n.txv = 1'b0;
                    n.tx = TX_IDLE;
                end
            end
            default: begin
                n.txv = 1'b0;
                n.tx = TX_IDLE;
            end
        endcase
    end

    // State register; reset gives idle, all outputs inactive.
    // Reset loads only constants; the assignment and polarity defaults come from the package.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s <= '0;
            s.asn <= ITM_ASN_RST;
            s.pol <= ITM_POL_RST;
            s.fout <= ITM_FOUT_RST;
        end else begin
            s <= n;
        end
    end

    // Every output is a flip-flop of the state.
    // No logic follows the register, so the pins never glitch between edges.
    assign pready = s.pready;
    assign prdata = s.prdata;
    assign pslverr = s.pslverr;
    assign in_act = s.iact;
    assign out_pin = s.out;
    assign seq_start_ok = s.seq_ok;
    assign stop_motion = s.stop;
    assign tx_valid = s.txv;
    assign tx_data = s.txd;

    // Checks sample on the bus clock and rest while reset is held.
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    chk_entry_refused: assert property (wr && paddr == ITM_A_CTRL && pwdata[ITM_C_ENTER] && !s.test
        && (seq_running || motion_active || alarm_active) |=> !s.test && s.refused)
        else $error("test mode entered while busy");
    chk_seq_blocked: assert property (s.test |=> !seq_start_ok)
        else $error("sequence start passed during test");
    chk_inputs_gated: assert property (s.test ##1 s.test |-> in_act == '0)
        else $error("inputs reached functions during test");
    chk_space_clear: assert property (rxv && s.test && ch == ITM_CH_SPC |=> ##1 out_pin == '0)
        else $error("space did not clear outputs");
    chk_exit_restore: assert property (rxv && s.test && ch == ITM_CH_ESC
        |=> !s.test ##1 out_pin == ($past(s.save, 2) & s.asn))
        else $error("outputs not restored on exit");
    chk_toggle_blocked: assert property (rxv && s.test && mapped && !s.asn[key[3:0]]
        |=> s.tout == $past(s.tout))
        else $error("unassigned output toggled");
    chk_toggle_flip: assert property (rxv && s.test && mapped && s.asn[key[3:0]]
        |=> s.tout == ($past(s.tout) ^ (13'h0001 << $past(key))))
        else $error("toggle did not invert one output");
    chk_query_pol: assert property (wr && paddr == ITM_A_CTRL && pwdata[ITM_C_QRY] && s.idx < 5'(ITM_NIN)
        |=> s.qry == $past(s.in_q[s.idx[3:0]] ^ s.pol[s.idx[3:0]]))
        else $error("query ignores polarity");
    chk_disp_send: assert property (s.disp && s.tx == TX_IDLE && s.tmr == 25'(DISP_CYC - 1)
        |=> tx_valid && tx_data == ITM_CH_ZERO + {7'h0, $past(qv)})
        else $error("display refresh not sent");
    chk_esc_display: assert property (rxv && !s.test && !s.rep && s.disp && ch == ITM_CH_ESC
        |=> !s.disp && !stop_motion)
        else $error("first escape not spent on display");
    chk_report_end: assert property (rxv && !s.test && s.rep && ch != ITM_CH_SPC |=> !s.rep)
        else $error("report not ended by other key");
    // Test levels move only on a received character, and they are what the pins show.
    chk_test_hold: assert property (s.test && !rxv |=> s.tout == $past(s.tout))
        else $error("test levels moved without a character");
    chk_test_pins: assert property (s.test |=> out_pin == $past(s.tout))
        else $error("pins not driven from test levels");
    // A successful entry remembers the levels that the pins showed.
    chk_entry_save: assert property (wr && paddr == ITM_A_CTRL && pwdata[ITM_C_ENTER] && !s.test
        && !(seq_running || motion_active || alarm_active) |=> s.test && s.save == $past(out_pin))
        else $error("entry levels not saved");
    // The value byte is always followed by the chosen line end.
    chk_line_end: assert property (s.tx == TX_VAL && tx_ready
        |=> tx_valid && tx_data == ($past(s.daisy) ? ITM_CH_LF : ITM_CH_CR))
        else $error("wrong line end after value");
    // Inputs stay readable in test mode as their logical state.
    chk_input_read: assert property (acc && !s.pready && paddr == ITM_A_IN
        |=> prdata == {23'h0, $past(lin)})
        else $error("input register not logical state");

    cov_test_toggle: cover property (s.test && rxv && mapped ##[1:20] rxv && ch == ITM_CH_ESC);
    cov_disp_tx: cover property (s.disp && tx_valid && tx_ready);
    cov_report_pages: cover property (s.rep && s.page == ITM_LAST_PAGE);
    cov_esc_stop: cover property (stop_motion);
    cov_entry_refused: cover property (wr && paddr == ITM_A_CTRL && pwdata[ITM_C_ENTER] ##1 s.refused);

endmodule : itm_monitor

// ---- itm_term.sv ----
`timescale 1ns/100ps

// Host terminal that takes the byte stream; it stalls at random when asked to be slow.
module itm_term (
    // Clock and reset.
    input wire logic pclk,
    input wire logic presetn,
    // Byte stream from the block.
    input wire logic tx_valid,
    input wire logic [7:0] tx_data,
    output logic tx_ready,
    // Stall control and the byte taken.
    input wire logic slow,
    output logic got,
    output logic [7:0] got_data
);
    // Ready moves only after an edge, so a byte is taken exactly where valid and ready meet.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tx_ready <= 1'b0;
            got <= 1'b0;
            got_data <= 8'h00;
        end else begin
            tx_ready <= slow ? 1'($urandom_range(0, 1)) : 1'b1;
            got <= tx_valid && tx_ready;
            got_data <= tx_data;
        end
    end
endmodule : itm_term

// ---- itm_monitor_test.sv ----
`timescale 1ns/100ps

module itm_monitor_test;
    import itm_pkg::*;
    // Short refresh period keeps the display run brief.
    localparam int DISP = 20;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic pready, pslverr, seq_start_ok, stop_motion, tx_valid, tx_ready, got;
    logic [31:0] prdata;
    logic [8:0] in_pin = 9'h000;
    logic [8:0] in_act;
    logic [12:0] out_pin;
    logic seq_running = 1'b0;
    logic motion_active = 1'b0;
    logic alarm_active = 1'b0;
    logic seq_start_req = 1'b0;
    logic slow = 1'b0;
    logic [7:0] tx_data, got_data;
    // Expected results, oldest first.
    logic [32:0] rdq[$];
    logic [7:0] txq[$];
    int tq[$];
    int fail_count = 0;
    int cmp_count = 0;
    int stops = 0;
    int cyc = 0;
    logic [12:0] asn, fout, exp_o;
    logic [8:0] pol, lg;
    // Toggle characters in output bit order.
    logic [7:0] tbl [13] = '{8'h31, 8'h32, 8'h33, 8'h34, 8'h4D, 8'h52, 8'h45, 8'h48, 8'h41, 8'h50, 8'h42, 8'h44,
        8'h4C};

    always #4 pclk = ~pclk;

    itm_monitor #(.DISP_CYC(DISP)) u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
        .in_pin(in_pin), .in_act(in_act), .out_pin(out_pin), .seq_running(seq_running),
        .motion_active(motion_active), .alarm_active(alarm_active), .seq_start_req(seq_start_req),
        .seq_start_ok(seq_start_ok), .stop_motion(stop_motion), .tx_valid(tx_valid), .tx_data(tx_data),
        .tx_ready(tx_ready));

    itm_term u_term (.pclk(pclk), .presetn(presetn), .tx_valid(tx_valid), .tx_data(tx_data),
        .tx_ready(tx_ready), .slow(slow), .got(got), .got_data(got_data));

    task automatic bad(input string what);
        fail_count++;
        $display("[FAIL] %0t %s", $time, what);
    endtask : bad

    task automatic cmp_rd(input logic [32:0] got_v, input logic [32:0] exp_v);
        cmp_count++;
        if (got_v !== exp_v) bad($sformatf("read %h expected %h", got_v, exp_v));
    endtask : cmp_rd

    task automatic cmp_tx(input logic [7:0] got_v, input logic [7:0] exp_v);
        cmp_count++;
        if (got_v !== exp_v) bad($sformatf("byte %h expected %h", got_v, exp_v));
    endtask : cmp_tx

    task automatic cmp_lv(input logic [31:0] got_v, input logic [31:0] exp_v);
        cmp_count++;
        if (got_v !== exp_v) bad($sformatf("level %h expected %h", got_v, exp_v));
    endtask : cmp_lv

    task automatic tally_and_finish;
        $display("Comparisons %0d, mismatches %0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : tally_and_finish

    // One APB transfer; entered just after an edge, and leaves one idle cycle behind it.
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (n >= 50) begin
            bad("no ready");
            tally_and_finish();
        end else begin
            psel <= 1'b0;
            penable <= 1'b0;
            @(posedge pclk);
        end
    endtask : apb

    task automatic rd(input logic [7:0] a, input logic [32:0] e);
        rdq.push_back(e);
        apb(1'b0, a, 32'h0);
    endtask : rd

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask : wr

    task automatic ch(input logic [7:0] c);
        wr(ITM_A_RX, {24'h0, c});
    endtask : ch

    task automatic pair(input logic [7:0] v, input logic [7:0] t);
        txq.push_back(v);
        txq.push_back(t);
    endtask : pair

    // Waits until every expected byte has been taken by the terminal.
    task automatic drain;
        int n;
        n = 0;
        while (txq.size() != 0 && n < 500) begin
            @(posedge pclk);
            n++;
        end
        if (n >= 500) begin
            bad("bytes missing");
            tally_and_finish();
        end
    endtask : drain

    // Watcher: every read answer takes the oldest note; an answer with no note compares against unknown.
    always @(posedge pclk) begin
        cyc++;
        if (stop_motion === 1'b1) stops++;
        if (pready === 1'b1 && !pwrite) cmp_rd({pslverr, prdata}, rdq.size() ? rdq.pop_front() : 'x);
        if (got === 1'b1) begin
            if (got_data inside {8'h30, 8'h31}) tq.push_back(cyc);
            cmp_tx(got_data, txq.size() ? txq.pop_front() : 'x);
        end
    end

    // A hang ends the run as a mismatch.
    initial begin
        repeat (20000) @(posedge pclk);
        bad("timeout");
        tally_and_finish();
    end

    initial begin
        void'($urandom(77));
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        rd(ITM_A_POL, 33'h0);
        rd(ITM_A_ASN, 33'h1FFF);
        rd(ITM_A_FOUT, 33'h0);
        rd(8'h24, {1'b1, 32'h0});
        // Bit 1 left unassigned so that a refused toggle is always seen.
        asn = (13'($urandom) & 13'h1FFD) | 13'h0001;
        fout = 13'($urandom);
        pol = 9'($urandom);
        in_pin <= 9'($urandom);
        wr(ITM_A_ASN, {19'h0, asn});
        wr(ITM_A_FOUT, {19'h0, fout});
        wr(ITM_A_POL, {23'h0, pol});
        lg = in_pin ^ pol;
        rd(ITM_A_IN, {24'h0, lg});
        cmp_lv(in_act, lg);
        // The capture samples the index already held, so the index is written first.
        for (int i = 0; i < 22; i++) begin
            wr(ITM_A_CTRL, i << ITM_C_IDX);
            wr(ITM_A_CTRL, 32'h8 | (i << ITM_C_IDX));
            rd(ITM_A_QRY, (i < 9) ? lg[i] : 33'((fout & asn) >> (i - 9)) & 33'h1);
        end
        // Each busy condition alone refuses entry.
        for (int k = 0; k < 3; k++) begin
            {seq_running, motion_active, alarm_active} <= 3'(1 << k);
            wr(ITM_A_CTRL, 32'h1);
            rd(ITM_A_STAT, 33'h8);
        end
        {seq_running, motion_active, alarm_active} <= 3'h0;
        seq_start_req <= 1'b1;
        wr(ITM_A_CTRL, 32'h1);
        rd(ITM_A_STAT, 33'h1);
        cmp_lv(in_act, 0);
        cmp_lv(seq_start_ok, 0);
        in_pin <= 9'($urandom);
        repeat (6) @(posedge pclk);
        lg = in_pin ^ pol;
        rd(ITM_A_IN, {24'h0, lg});
        exp_o = fout & asn;
        for (int i = 0; i < 13; i++) begin
            ch(tbl[i]);
            if (asn[i]) exp_o[i] = ~exp_o[i];
            rd(ITM_A_OUT, {20'h0, exp_o});
        end
        ch(8'h5A);
        ch(8'h2F);
        rd(ITM_A_OUT, {20'h0, exp_o});
        cmp_lv(out_pin, exp_o);
        ch(ITM_CH_SPC);
        rd(ITM_A_OUT, 33'h0);
        ch(tbl[0]);
        ch(ITM_CH_ESC);
        rd(ITM_A_OUT, {20'h0, fout & asn});
        rd(ITM_A_STAT, 33'h0);
        cmp_lv(seq_start_ok, 1);
        // Display of input 0 with line feeds; the host's space-slash request maps to this write.
        tq.delete();
        pair(ITM_CH_ZERO | lg[0], ITM_CH_LF);
        pair(ITM_CH_ZERO | lg[0], ITM_CH_LF);
        wr(ITM_A_CTRL, 32'h12);
        drain();
        ch(ITM_CH_ESC);
        rd(ITM_A_STAT, 33'h0);
        cmp_lv(tq[1] - tq[0], DISP);
        // Display during motion: first escape ends it, second stops the motion.
        motion_active <= 1'b1;
        pair(ITM_CH_ZERO | lg[0], ITM_CH_CR);
        wr(ITM_A_CTRL, 32'h2);
        drain();
        ch(ITM_CH_ESC);
        rd(ITM_A_STAT, 33'h0);
        cmp_lv(stops, 0);
        ch(ITM_CH_ESC);
        // The pulse is raised at the edge before the task returns; the watcher counts it at the edge where the task returns.
        @(posedge pclk);
        cmp_lv(stops, 1);
        motion_active <= 1'b0;
        // Report with a stalling terminal: other key quits, space pages on.
        slow <= 1'b1;
        pair(ITM_CH_ZERO, ITM_CH_CR);
        wr(ITM_A_CTRL, 32'h4);
        rd(ITM_A_STAT, 33'h4);
        drain();
        ch(8'h78);
        rd(ITM_A_STAT, 33'h0);
        pair(ITM_CH_ZERO, ITM_CH_CR);
        wr(ITM_A_CTRL, 32'h4);
        for (int p = 1; p < 4; p++) begin
            drain();
            pair(ITM_CH_ZERO | 8'(p), ITM_CH_CR);
            ch(ITM_CH_SPC);
        end
        drain();
        // A space on the last page ends the report and leaves the page count standing.
        ch(ITM_CH_SPC);
        rd(ITM_A_STAT, 33'h30);
        repeat (40) @(posedge pclk);
        tally_and_finish();
    end
endmodule : itm_monitor_test
